// file: pkg/iop_pkg.sv
package iop_pkg;
   localparam int DATA_W = 8;
   localparam int PORT_D_W = 3;
   localparam int PIN_W = 27;
   localparam int CELL_W = 16;
   localparam int SYNC_W = 27;

   // Register offsets: type base plus port index in the two low bits
   localparam logic [7:0] OFS_DATA_IN = 8'h00;
   localparam logic [7:0] OFS_FUNC_SEL = 8'h04;
   localparam logic [7:0] OFS_DIRECTION = 8'h08;
   localparam logic [7:0] OFS_DRIVE_SEL = 8'h0C;
   localparam logic [7:0] OFS_OUT_VALUE = 8'h10;
   localparam logic [7:0] OFS_CELL_VALUE = 8'h14;
   localparam logic [7:0] OFS_CELL_MASK = 8'h18;
   localparam logic [7:0] OFS_INPUT_CELL = 8'h1C;
   localparam logic [7:0] OFS_DRV_ENABLE = 8'h20;

   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;
   localparam logic [1:0] PORT_D = 2'h3;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] PORT_FULL_MASK = 8'hFF;
   localparam logic [7:0] PORT_D_MASK = 8'h07;
   localparam logic [7:0] DRV_OD_AB = 8'hF0;
   localparam logic [7:0] DRV_SLEW_AB = 8'h0F;

   // Dedicated input roles of the fourth port pins
   localparam int PIN_D_STROBE = 0;
   localparam int PIN_D_LCLK = 1;
   localparam int PIN_D_CSEL = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } iop_bus_s;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [2:0] d;
   } iop_pins_s;
endpackage

// file: rtl/iop_sync.sv
`timescale 1ns/10ps
module iop_sync #(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_r <= '0;
         q_out <= '0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // iop_sync

// file: rtl/iop_pin_drv.sv
`timescale 1ns/10ps
module iop_pin_drv #(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] data_in,
   input wire logic [W-1:0] enable_in,
   input wire logic [W-1:0] open_drain_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe_n_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               pin_out[i] <= 1'b0;
               pin_oe_n_out[i] <= 1'b1;
            end else begin
               // Open drain only pulls low; a high is left to the pull-up
               pin_out[i] <= data_in[i] & ~open_drain_in[i];
               pin_oe_n_out[i] <= ~enable_in[i] |
                                  (open_drain_in[i] & data_in[i]);
            end
         end
      end
   endgenerate
endmodule // iop_pin_drv

// file: rtl/iop_port_regs.sv
`timescale 1ns/10ps
// Contract
// - Drive-select one makes a capable pin open-drain; zero keeps push-pull.
// - Drive-select one selects fast edges on slew pins; zero selects slow.
// - Ports A, B: bits 7-4 open-drain select, bits 3-0 fast-slew select.
// - Port C: all eight drive bits are open-drain selects, no slew.
// - Port D: drive bits 2-0 fast slew, bits 7-3 unused.
// - Without output-enable term, direction zero is input, one is output.
// - With output-enable term, pin drives if direction or term is one.
// - Output value register stores writes, drives pins enabled by direction with term zero, reads back.
// - Data-in location returns current pin levels, no storage.
// - Cell location reads cell outputs; writes load unmasked cell flops.
// - Mask bit one blocks processor load of its cell; resets to zero.
// - Input cells latch pins, feed the logic array, read by processor.
// - Enable-out read gives each port A-C pin's effective driver enable.
// - Only ports A and B have a function select register.
// - Port D goes straight to the array; no cell locations there.
// - Low cell group routes to A or B; high group to B or C.
// - Port A may serve as data bus and alone offers peripheral mode.
// - Chip-select pin high deselects memories and configuration space.
// - Port D carries the address strobe and the logic clock input.
// - Function select zero gives processor I/O, one latched address out.
// - Function, direction and drive registers reset to zero.
// - Registers reached by plain bus reads and writes at fixed offsets.
module iop_port_regs (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire iop_pkg::iop_bus_s mcu_bus_in,
   input wire logic config_select_in,
   input wire logic chip_select_assign_in,
   input wire logic data_port_mode_in,
   input wire logic periph_mode_in,
   input wire logic periph_sel_in,
   input wire logic group_low_to_b_in,
   input wire logic group_high_to_c_in,
   input wire logic [15:0] cell_array_d_in,
   input wire iop_pkg::iop_pins_s oe_term_in,
   input wire iop_pkg::iop_pins_s pins_in,
   output iop_pkg::iop_pins_s pins_out,
   output iop_pkg::iop_pins_s pins_oe_n_out,
   output iop_pkg::iop_pins_s open_drain_out,
   output iop_pkg::iop_pins_s slew_fast_out,
   output logic [7:0] rdata_out,
   output logic rd_ack_out,
   output logic [23:0] input_cell_out,
   output logic [15:0] output_cell_out,
   output logic [2:0] port_d_array_out,
   output logic memory_deselect_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   iop_pkg::iop_pins_s pins_sync;
   logic [7:0] lvl [4];
   logic [7:0] oe_t [4];
   logic [7:0] en [4];
   logic [7:0] pdata [4];
   logic [7:0] od_sel [4];
   logic [7:0] cell_view [4];
   logic [7:0] func_r [2];
   logic [7:0] dir_r [4];
   logic [7:0] drive_r [4];
   logic [7:0] dout_r [4];
   logic [7:0] mask_r [3];
   logic [7:0] icell_r [3];
   logic [7:0] cell_low_r;
   logic [7:0] cell_high_r;
   logic [7:0] cell_low_nxt;
   logic [7:0] cell_high_nxt;
   logic [7:0] addr_latch_r;
   logic [7:0] rdata_nxt;
   logic [2:0] port_d_r;
   logic lclk_prev_r;
   logic deselect_r;
   logic ack_r;
   logic strobe;
   logic lclk_rise;
   logic deselect;
   logic acc_ok;
   logic wr_ok;
   logic rd_ok;
   logic bus_mode_a;
   logic relay_a;

   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] ofs,
                                    input logic [1:0] p);
      return a == (ofs | {6'h00, p});
   endfunction

   function automatic logic [7:0] port_mask(input logic [1:0] p);
      return (p == iop_pkg::PORT_D) ? iop_pkg::PORT_D_MASK
                                    : iop_pkg::PORT_FULL_MASK;
   endfunction

   // All pin levels pass two flops before any use
   iop_sync #(.W(iop_pkg::SYNC_W)) u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .d_in(pins_in),
      .q_out(pins_sync)
   );

   assign lvl[0] = pins_sync.a;
   assign lvl[1] = pins_sync.b;
   assign lvl[2] = pins_sync.c;
   assign lvl[3] = {5'h00, pins_sync.d};
   assign oe_t[0] = oe_term_in.a;
   assign oe_t[1] = oe_term_in.b;
   assign oe_t[2] = oe_term_in.c;
   assign oe_t[3] = {5'h00, oe_term_in.d};

   assign strobe = pins_sync.d[iop_pkg::PIN_D_STROBE];
   assign lclk_rise = pins_sync.d[iop_pkg::PIN_D_LCLK] & ~lclk_prev_r;
   assign deselect = chip_select_assign_in &
                     pins_sync.d[iop_pkg::PIN_D_CSEL];
   assign acc_ok = config_select_in & ~deselect;
   assign wr_ok = mcu_bus_in.wr & acc_ok;
   assign rd_ok = mcu_bus_in.rd & acc_ok;
   assign bus_mode_a = data_port_mode_in | relay_a;
   assign relay_a = periph_mode_in & periph_sel_in;

   // Function, direction and drive selects
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int p = 0; p < 4; p++) begin
            dir_r[p] <= iop_pkg::REG_RESET;
            drive_r[p] <= iop_pkg::REG_RESET;
         end
         for (int p = 0; p < 2; p++) begin
            func_r[p] <= iop_pkg::REG_RESET;
         end
      end else if (wr_ok) begin
         for (int p = 0; p < 4; p++) begin
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DIRECTION, 2'(p))) begin
               dir_r[p] <= mcu_bus_in.wdata & port_mask(2'(p));
            end
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DRIVE_SEL, 2'(p))) begin
               drive_r[p] <= mcu_bus_in.wdata & port_mask(2'(p));
            end
         end
         for (int p = 0; p < 2; p++) begin
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_FUNC_SEL, 2'(p))) begin
               func_r[p] <= mcu_bus_in.wdata;
            end
         end
      end
   end

   // Output values and cell load masks
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int p = 0; p < 4; p++) begin
            dout_r[p] <= iop_pkg::REG_RESET;
         end
         for (int p = 0; p < 3; p++) begin
            mask_r[p] <= iop_pkg::REG_RESET;
         end
      end else if (wr_ok) begin
         for (int p = 0; p < 4; p++) begin
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_OUT_VALUE, 2'(p))) begin
               dout_r[p] <= mcu_bus_in.wdata & port_mask(2'(p));
            end
         end
         for (int p = 0; p < 3; p++) begin
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_MASK, 2'(p))) begin
               mask_r[p] <= mcu_bus_in.wdata;
            end
         end
      end
   end

   // Which cell group each port sees
   always_comb begin
      cell_view[0] = group_low_to_b_in ? 8'h00 : cell_low_r;
      cell_view[1] = group_low_to_b_in ? cell_low_r :
                     (group_high_to_c_in ? 8'h00 : cell_high_r);
      cell_view[2] = group_high_to_c_in ? cell_high_r : 8'h00;
      cell_view[3] = 8'h00;
   end

   // Processor load wins over the array clock edge in the same cycle
   always_comb begin
      cell_low_nxt = lclk_rise ? cell_array_d_in[7:0] : cell_low_r;
      cell_high_nxt = lclk_rise ? cell_array_d_in[15:8] : cell_high_r;
      if (wr_ok) begin
         for (int p = 0; p < 3; p++) begin
            if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_VALUE, 2'(p))) begin
               if ((p == 0 && !group_low_to_b_in) ||
                   (p == 1 && group_low_to_b_in)) begin
                  cell_low_nxt = (cell_low_nxt & mask_r[p]) |
                                 (mcu_bus_in.wdata & ~mask_r[p]);
               end
               if ((p == 1 && !group_low_to_b_in && !group_high_to_c_in) ||
                   (p == 2 && group_high_to_c_in)) begin
                  cell_high_nxt = (cell_high_nxt & mask_r[p]) |
                                  (mcu_bus_in.wdata & ~mask_r[p]);
               end
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cell_low_r <= iop_pkg::REG_RESET;
         cell_high_r <= iop_pkg::REG_RESET;
         lclk_prev_r <= 1'b0;
      end else begin
         cell_low_r <= cell_low_nxt;
         cell_high_r <= cell_high_nxt;
         lclk_prev_r <= pins_sync.d[iop_pkg::PIN_D_LCLK];
      end
   end

   // Input cells and address latch follow the strobe, hold when it drops
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int p = 0; p < 3; p++) begin
            icell_r[p] <= iop_pkg::REG_RESET;
         end
         addr_latch_r <= iop_pkg::REG_RESET;
         port_d_r <= 3'h0;
         deselect_r <= 1'b0;
      end else begin
         if (strobe) begin
            for (int p = 0; p < 3; p++) begin
               icell_r[p] <= lvl[p];
            end
            addr_latch_r <= mcu_bus_in.addr;
         end
         port_d_r <= pins_sync.d;
         deselect_r <= deselect;
      end
   end

   // Pin data and effective driver enable
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         en[p] = (dir_r[p] | oe_t[p]) & port_mask(2'(p));
         pdata[p] = (oe_t[p] & cell_view[p]) | (~oe_t[p] & dout_r[p]);
      end
      for (int p = 0; p < 2; p++) begin
         pdata[p] = (func_r[p] & addr_latch_r) |
                    (~func_r[p] & pdata[p]);
         en[p] = en[p] | func_r[p];
      end
      if (bus_mode_a) begin
         pdata[0] = mcu_bus_in.wdata;
         en[0] = {8{mcu_bus_in.wr}};
      end
      od_sel[0] = drive_r[0] & iop_pkg::DRV_OD_AB;
      od_sel[1] = drive_r[1] & iop_pkg::DRV_OD_AB;
      od_sel[2] = drive_r[2];
      od_sel[3] = 8'h00;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_port
         logic [7:0] drv_val;
         logic [7:0] drv_oe_n;
         iop_pin_drv #(.W(8)) u_drv (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .data_in(pdata[g]),
            .enable_in(en[g]),
            .open_drain_in(od_sel[g]),
            .pin_out(drv_val),
            .pin_oe_n_out(drv_oe_n)
         );
      end
   endgenerate

   assign pins_out = {g_port[0].drv_val, g_port[1].drv_val,
                      g_port[2].drv_val, g_port[3].drv_val[2:0]};
   assign pins_oe_n_out = {g_port[0].drv_oe_n, g_port[1].drv_oe_n,
                           g_port[2].drv_oe_n, g_port[3].drv_oe_n[2:0]};
   assign open_drain_out = {od_sel[0], od_sel[1], drive_r[2], 3'h0};
   assign slew_fast_out = {drive_r[0] & iop_pkg::DRV_SLEW_AB,
                           drive_r[1] & iop_pkg::DRV_SLEW_AB,
                           8'h00, drive_r[3][2:0]};
   assign input_cell_out = {icell_r[2], icell_r[1], icell_r[0]};
   assign output_cell_out = {cell_high_r, cell_low_r};
   assign port_d_array_out = port_d_r;
   assign memory_deselect_out = deselect_r;

   // Read mux; unmapped offsets return zero
   always_comb begin
      rdata_nxt = 8'h00;
      for (int p = 0; p < 4; p++) begin
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DATA_IN, 2'(p))) begin
            rdata_nxt = lvl[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_OUT_VALUE, 2'(p))) begin
            rdata_nxt = dout_r[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DIRECTION, 2'(p))) begin
            rdata_nxt = dir_r[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DRIVE_SEL, 2'(p))) begin
            rdata_nxt = drive_r[p];
         end
      end
      for (int p = 0; p < 2; p++) begin
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_FUNC_SEL, 2'(p))) begin
            rdata_nxt = func_r[p];
         end
      end
      for (int p = 0; p < 3; p++) begin
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_VALUE, 2'(p))) begin
            rdata_nxt = cell_view[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_MASK, 2'(p))) begin
            rdata_nxt = mask_r[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_INPUT_CELL, 2'(p))) begin
            rdata_nxt = icell_r[p];
         end
         if (reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DRV_ENABLE, 2'(p))) begin
            rdata_nxt = en[p];
         end
      end
      // Peripheral relay passes port A levels to the processor
      if (relay_a) begin
         rdata_nxt = lvl[0];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= 8'h00;
         ack_r <= 1'b0;
      end else begin
         if (rd_ok) begin
            rdata_out <= rdata_nxt;
         end
         ack_r <= rd_ok;
      end
   end
   assign rd_ack_out = ack_r;

   a_dout_readback: assert property (
      rd_ok && !relay_a &&
      reg_hit(mcu_bus_in.addr, iop_pkg::OFS_OUT_VALUE, 2'h0)
      |=> rd_ack_out && rdata_out == $past(dout_r[0]))
      else $error("output value readback mismatch");

   a_din_level: assert property (
      rd_ok && !relay_a &&
      reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DATA_IN, 2'h2)
      |=> rdata_out == $past(lvl[2]))
      else $error("data in does not show pin level");

   // An open-drain pin may only pull low, never push a high
   a_od_release: assert property (
      1'b1 |=> (pins_out.c & $past(drive_r[2])) == 8'h00)
      else $error("open drain pin driven high on port C");

   a_slew_map: assert property (
      wr_ok && reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DRIVE_SEL, 2'h0)
      |=> slew_fast_out.a == {4'h0, $past(mcu_bus_in.wdata[3:0])} &&
          open_drain_out.a == {$past(mcu_bus_in.wdata[7:4]), 4'h0})
      else $error("port A drive select split wrong");

   a_c_od_only: assert property (
      slew_fast_out.c == 8'h00 && open_drain_out.c == drive_r[2])
      else $error("port C offers slew or lacks open drain");

   a_d_slew_low: assert property (
      wr_ok && reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DRIVE_SEL, 2'h3)
      |=> slew_fast_out.d == $past(mcu_bus_in.wdata[2:0]) &&
          drive_r[3][7:3] == 5'h00)
      else $error("port D slew select wrong");

   a_dir_input: assert property (
      !dir_r[2][0] && !oe_term_in.c[0] |=> pins_oe_n_out.c[0])
      else $error("pin driven with direction and term zero");

   a_dir_or_term: assert property (
      (dir_r[2][0] || oe_term_in.c[0]) && !drive_r[2][0]
      |=> !pins_oe_n_out.c[0])
      else $error("pin not driven with direction or term set");

   a_mask_block: assert property (
      wr_ok && group_high_to_c_in && mask_r[2] == 8'hFF && !lclk_rise &&
      reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_VALUE, 2'h2)
      |=> $stable(cell_high_r))
      else $error("masked cell was loaded");

   a_cell_load: assert property (
      wr_ok && group_high_to_c_in && mask_r[2] == 8'h00 &&
      reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_VALUE, 2'h2)
      |=> cell_high_r == $past(mcu_bus_in.wdata))
      else $error("unmasked cell not loaded");

   a_deselect_wr: assert property (
      deselect && mcu_bus_in.wr &&
      reg_hit(mcu_bus_in.addr, iop_pkg::OFS_DIRECTION, 2'h0)
      |=> $stable(dir_r[0]) && memory_deselect_out)
      else $error("deselected access took effect");

   a_d_upper_zero: assert property (
      dir_r[3][7:3] == 5'h00 && dout_r[3][7:3] == 5'h00)
      else $error("port D upper bits stored");

   c_cell_write: cover property (
      wr_ok && reg_hit(mcu_bus_in.addr, iop_pkg::OFS_CELL_VALUE, 2'h0));
   c_lclk_load: cover property (lclk_rise ##1 output_cell_out != 16'h0000);
   c_relay_read: cover property (rd_ok && relay_a ##1 rd_ack_out);
   c_addr_out: cover property (func_r[0] != 8'h00 && strobe);
endmodule // iop_port_regs

// file: testbench/iop_board.sv
`timescale 1ns/10ps
module iop_board (
   input wire iop_pkg::iop_pins_s drive_in,
   input wire iop_pkg::iop_pins_s oe_n_in,
   input wire iop_pkg::iop_pins_s od_in,
   input wire iop_pkg::iop_pins_s ext_in,
   output iop_pkg::iop_pins_s level_out
);
   // Driven pins see their drive, released open-drain pins the pull-up, other released pins the outside source
   assign level_out = (~oe_n_in & drive_in) | (oe_n_in & od_in)
      | (oe_n_in & ~od_in & ext_in);
endmodule // iop_board

// file: testbench/test_mcu_io_port_registers.sv
`timescale 1ns/10ps
module test_mcu_io_port_registers;
   logic clk_in;
   logic reset_n_in;
   logic cfg_sel;
   logic cs_assign;
   logic dport, pmode, psel, grp_lo, grp_hi;
   logic rd_ack;
   logic desel;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [7:0] e;
   logic [23:0] icell;
   logic [15:0] ocell;
   logic [15:0] cell_d;
   logic [2:0] pd;
   iop_pkg::iop_bus_s bus;
   iop_pkg::iop_pins_s oe_term, lvl, drv, oe_n, od, slew, ext;
   logic [7:0] exp_q[$];
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int seed = 23;

   iop_port_regs i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .mcu_bus_in(bus), .config_select_in(cfg_sel),
      .chip_select_assign_in(cs_assign), .data_port_mode_in(dport),
      .periph_mode_in(pmode), .periph_sel_in(psel),
      .group_low_to_b_in(grp_lo), .group_high_to_c_in(grp_hi),
      .cell_array_d_in(cell_d), .oe_term_in(oe_term), .pins_in(lvl),
      .pins_out(drv), .pins_oe_n_out(oe_n), .open_drain_out(od),
      .slew_fast_out(slew), .rdata_out(rdata), .rd_ack_out(rd_ack),
      .input_cell_out(icell), .output_cell_out(ocell),
      .port_d_array_out(pd), .memory_deselect_out(desel));

   iop_board i_board (.drive_in(drv), .oe_n_in(oe_n), .od_in(od),
      .ext_in(ext), .level_out(lvl));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   function automatic logic [7:0] ad(input logic [7:0] o, input int p);
      return o + 8'(p);
   endfunction

   task automatic cmp(input string nm, input logic [7:0] x,
                      input logic [7:0] g);
      n_checks++;
      if (g !== x) begin
         $display("mismatch %s expected %h seen %h", nm, x, g);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      bus.addr = a;
      bus.wdata = d;
      bus.wr = 1'b1;
      @(negedge clk_in);
      bus.wr = 1'b0;
   endtask

   // Refused reads push nothing, so a stray ack shows as a mismatch
   task automatic rd(input logic [7:0] a, input logic [7:0] x,
                     input bit ack = 1'b1);
      @(negedge clk_in);
      bus.addr = a;
      bus.rd = 1'b1;
      if (ack)
         exp_q.push_back(x);
      @(negedge clk_in);
      bus.rd = 1'b0;
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(negedge clk_in) begin
      if (rd_ack === 1'b1) begin
         if (exp_q.size() == 0)
            cmp("rd_ack", 8'h00, 8'h01);
         else
            cmp("rdata", exp_q.pop_front(), rdata);
      end
   end

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         cmp("timeout", 8'h00, 8'h01);
         end_of_test();
      end
   end

   initial begin
      reset_n_in = 1'b0;
      bus = '0;
      cfg_sel = 1'b1;
      cs_assign = 1'b0;
      dport = 1'b0;
      pmode = 1'b0;
      psel = 1'b0;
      grp_lo = 1'b0;
      grp_hi = 1'b0;
      oe_term = '0;
      ext = '0;
      cell_d = 16'h0000;
      repeat (16) @(negedge clk_in);
      reset_n_in = 1'b1;
      cmp("oe_n a", 8'hFF, oe_n.a);
      for (int p = 0; p < 4; p++) begin
         rd(ad(iop_pkg::OFS_FUNC_SEL, p), 8'h00);
         rd(ad(iop_pkg::OFS_DIRECTION, p), 8'h00);
         rd(ad(iop_pkg::OFS_DRIVE_SEL, p), 8'h00);
         e = (p == 3) ? iop_pkg::PORT_D_MASK : iop_pkg::PORT_FULL_MASK;
         v = 8'($random(seed));
         wr(ad(iop_pkg::OFS_DIRECTION, p), v);
         rd(ad(iop_pkg::OFS_DIRECTION, p), v & e);
         wr(ad(iop_pkg::OFS_DIRECTION, p), 8'h00);
         wr(ad(iop_pkg::OFS_OUT_VALUE, p), v);
         rd(ad(iop_pkg::OFS_OUT_VALUE, p), v & e);
         wr(ad(iop_pkg::OFS_FUNC_SEL, p), v);
         rd(ad(iop_pkg::OFS_FUNC_SEL, p), (p < 2) ? v : 8'h00);
         wr(ad(iop_pkg::OFS_FUNC_SEL, p), 8'h00);
      end
      v = 8'($random(seed));
      for (int p = 0; p < 4; p++)
         wr(ad(iop_pkg::OFS_DRIVE_SEL, p), v);
      cmp("od a", v & iop_pkg::DRV_OD_AB, od.a);
      cmp("slew b", v & iop_pkg::DRV_SLEW_AB, slew.b);
      cmp("od c", v, od.c);
      cmp("slew c", 8'h00, slew.c);
      cmp("slew d", {5'h00, v[2:0]}, {5'h00, slew.d});
      cmp("od d", 8'h00, {5'h00, od.d});
      for (int p = 0; p < 4; p++)
         wr(ad(iop_pkg::OFS_DRIVE_SEL, p), 8'h00);
      // Port A: three outputs by direction, two more by enable term
      v = 8'($random(seed));
      e = 8'($random(seed));
      ext.a = e;
      wr(iop_pkg::OFS_DIRECTION, 8'h07);
      wr(iop_pkg::OFS_OUT_VALUE, v);
      oe_term.a = 8'h30;
      repeat (3) @(negedge clk_in);
      cmp("oe_n a", 8'hC8, oe_n.a);
      cmp("drv a", v & 8'h07, drv.a & 8'h07);
      rd(iop_pkg::OFS_DRV_ENABLE, 8'h37);
      rd(iop_pkg::OFS_DATA_IN, (v & 8'h07) | (e & 8'hC8));
      oe_term.a = 8'h00;
      wr(iop_pkg::OFS_DIRECTION, 8'h00);
      @(negedge clk_in);
      cmp("oe_n a", 8'hFF, oe_n.a);
      // Open-drain port C released high reads back through pull-ups
      wr(ad(iop_pkg::OFS_DRIVE_SEL, 2), 8'hFF);
      wr(ad(iop_pkg::OFS_OUT_VALUE, 2), 8'hFF);
      wr(ad(iop_pkg::OFS_DIRECTION, 2), 8'hFF);
      repeat (3) @(negedge clk_in);
      cmp("oe_n c", 8'hFF, oe_n.c);
      cmp("drv c", 8'h00, drv.c);
      rd(ad(iop_pkg::OFS_DATA_IN, 2), 8'hFF);
      wr(iop_pkg::OFS_CELL_MASK, 8'h0F);
      rd(iop_pkg::OFS_CELL_MASK, 8'h0F);
      wr(iop_pkg::OFS_CELL_VALUE, 8'hFF);
      rd(iop_pkg::OFS_CELL_VALUE, 8'hF0);
      cmp("cell low", 8'hF0, ocell[7:0]);
      cell_d = 16'($random(seed));
      ext.d = 3'h2;
      repeat (4) @(negedge clk_in);
      cmp("port d", 8'h02, {5'h00, pd});
      ext.d = 3'h0;
      rd(iop_pkg::OFS_CELL_VALUE, cell_d[7:0]);
      e = 8'($random(seed));
      ext.b = e;
      ext.d = 3'h1;
      repeat (4) @(negedge clk_in);
      ext.d = 3'h0;
      rd(ad(iop_pkg::OFS_INPUT_CELL, 1), e);
      cmp("icell b", e, icell[15:8]);
      // Low group to port B, high group to port C
      grp_lo = 1'b1;
      grp_hi = 1'b1;
      wr(ad(iop_pkg::OFS_CELL_VALUE, 2), v);
      rd(ad(iop_pkg::OFS_CELL_VALUE, 2), v);
      wr(ad(iop_pkg::OFS_CELL_MASK, 2), 8'hFF);
      wr(ad(iop_pkg::OFS_CELL_VALUE, 2), ~v);
      rd(ad(iop_pkg::OFS_CELL_VALUE, 2), v);
      rd(iop_pkg::OFS_CELL_VALUE, 8'h00);
      rd(ad(iop_pkg::OFS_CELL_VALUE, 1), cell_d[7:0]);
      // Data port mode drives write data on port A, registered one clock behind wr
      dport = 1'b1;
      wr(ad(iop_pkg::OFS_FUNC_SEL, 3), v);
      cmp("bus a", v, drv.a);
      cmp("bus oe_n a", 8'h00, oe_n.a);
      dport = 1'b0;
      repeat (3) @(negedge clk_in);
      pmode = 1'b1;
      psel = 1'b1;
      rd(iop_pkg::OFS_DIRECTION, ext.a);
      pmode = 1'b0;
      psel = 1'b0;
      cs_assign = 1'b1;
      ext.d = 3'h4;
      repeat (3) @(negedge clk_in);
      cmp("deselect", 8'h01, {7'h00, desel});
      wr(iop_pkg::OFS_DIRECTION, 8'hAA);
      rd(iop_pkg::OFS_DIRECTION, 8'h00, 1'b0);
      ext.d = 3'h0;
      repeat (3) @(negedge clk_in);
      rd(iop_pkg::OFS_DIRECTION, 8'h00);
      repeat (4) @(negedge clk_in);
      cmp("pending reads", 8'h00, 8'(exp_q.size()));
      end_of_test();
   end
endmodule // test_mcu_io_port_registers
